// ===== include/dcs_map.svh
// Constants of the DDR2 command scheduler: field positions, timing and counts.
// Assumes a 125 MHz controller clock; included by bare name.
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH
// Clock period and DRAM timing, in picoseconds
`define DCS_CLK_PS 8000
`define DCS_TRCD_PS 15000
`define DCS_TRP_PS 15000
// Least times round up to whole cycles
`define DCS_TRCD_CYC ((`DCS_TRCD_PS + `DCS_CLK_PS - 1) / `DCS_CLK_PS)
`define DCS_TRP_CYC ((`DCS_TRP_PS + `DCS_CLK_PS - 1) / `DCS_CLK_PS)
// Burst geometry on the 16-bit device
`define DCS_BURST_BYTES 8
`define DCS_BURST_SHIFT 3
// Byte address field positions
`define DCS_COL_LSB 1
`define DCS_ILV_BANK_LSB 11
`define DCS_ILV_ROW_LSB 14
`define DCS_LIN_ROW_LSB 11
`define DCS_LIN_BANK_LSB 24
// Mapping mode values
`define DCS_MAP_INTERLEAVE 1'b0
`endif

// ===== include/dcs_pkg.sv
// Types of the DDR2 command scheduler.
// Assumes nothing beyond a SystemVerilog compiler.
package dcs_pkg;
  typedef logic [2:0] dcs_bank_t;
  typedef logic [12:0] dcs_row_t;
  typedef logic [9:0] dcs_col_t;
  // DRAM command opcodes
  typedef enum logic [2:0] {
    DCS_OP_NOP = 3'h0,
    DCS_OP_ACT = 3'h1,
    DCS_OP_RD = 3'h2,
    DCS_OP_WR = 3'h3,
    DCS_OP_PRE = 3'h4
  } dcs_op_t;
  // Scheduler states
  typedef enum logic [0:0] {
    DCS_ST_IDLE = 1'b0,
    DCS_ST_RUN = 1'b1
  } dcs_state_t;
  // One crossbar request
  typedef struct packed {
    logic valid;
    logic [15:0] masterId;
    logic write;
    logic [31:0] addr;
    logic [7:0] size;
  } dcs_req_t;
  // One DRAM command
  typedef struct packed {
    dcs_op_t op;
    dcs_bank_t bank;
    dcs_row_t row;
    dcs_col_t col;
    logic autoPre;
  } dcs_cmd_t;
  // Decoded DRAM location
  typedef struct packed {
    dcs_bank_t bank;
    dcs_row_t row;
    dcs_col_t col;
  } dcs_loc_t;
endpackage : dcs_pkg

// ===== verilog/dcs_bank.sv
// One DRAM bank: open flag, open row and a busy timer.
// Assumes strobes from the scheduler on the same clock, at most one per cycle.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_map.svh"
module dcs_bank
  import dcs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sysRst,
  // Command strobes
  input wire logic doAct,
  input wire logic doPre,
  input wire logic doAutoPre,
  input wire dcs_row_t actRow,
  input wire logic [3:0] actWait,
  // Bank state
  output logic openFlag,
  output dcs_row_t openRow,
  output wire logic ready
);
  logic [3:0] timer;

  // Open state; other banks are never touched by this one
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      openFlag <= 1'b0;
      openRow <= '0;
    end else if (doAct) begin
      openFlag <= 1'b1;
      openRow <= actRow;
    end else if (doPre || doAutoPre) begin
      openFlag <= 1'b0;
    end
  end

  // Busy timer: row-to-column after activate, precharge time after close
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      timer <= 4'h0;
    end else if (doAct) begin
      timer <= actWait;
    end else if (doPre || doAutoPre) begin
      timer <= 4'(`DCS_TRP_CYC);
    end else if (timer != 4'h0) begin
      timer <= timer - 4'h1;
    end
  end

  assign ready = (timer == 4'h0);

  property p_pre_wait;
    @(posedge mclk) disable iff (sysRst) (doPre || doAutoPre) |=> !ready;
  endproperty
  a_pre_wait: assert property (p_pre_wait) else $error("bank ready right after precharge");
endmodule : dcs_bank
`default_nettype wire

// ===== verilog/dcs_scheduler.sv
// DDR2 command scheduler: arbitration, bank mapping, page handling, auto precharge.
// Assumes requests and settings come from logic on mclk; commands go to a DRAM PHY.
// Overview of operation
// - Mapping mode 0 places the bank bits just above the column so strides spread over banks.
// - A row may be activated in one bank while rows stay open in the other banks.
// - An access that hits the open row of its bank gets its column command with no precharge.
// - With the global read auto-precharge bit set every read carries auto precharge.
// - Eight per-bank enables give auto precharge only on the last burst of a read transfer.
// - The global bit overrides the per-bank enables for reads on every bank.
// - With additive latency of the row-to-column delay minus one, the read follows activate at once.
// - A request whose master ID matches the priority ID on the masked bits wins arbitration over one that does not.
// - Each read or write burst moves 8 bytes, four 16-bit words.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_map.svh"
module dcs_scheduler
  import dcs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sysRst,
  // Configuration
  input wire logic bankMappingMode,
  input wire logic globalReadAutoprecharge,
  input wire logic [7:0] perBankAutoprechargeEnables,
  input wire logic [15:0] priorityMasterId,
  input wire logic [15:0] priorityIdMask,
  input wire logic [2:0] additiveLatency,
  // Crossbar requests
  input wire dcs_req_t req0,
  input wire dcs_req_t req1,
  output logic [1:0] reqAccept,
  // DRAM commands and bank state
  output var dcs_cmd_t cmdOut,
  output wire logic [7:0] bankOpen
);
  localparam int NBANK = 8;

  dcs_state_t state;
  logic [31:0] curAddr;
  logic curWrite;
  logic [5:0] burstsLeft;
  logic rrLast;
  logic issueLastQ;
  logic [7:0] prevOpen;
  dcs_loc_t loc;
  dcs_row_t openRowArr [NBANK];
  logic [7:0] bankReady;
  logic [7:0] doAct;
  logic [7:0] doPre;
  logic [7:0] doAutoPre;
  logic [3:0] actWait;
  logic pickOne;
  logic anyReq;
  dcs_req_t pickReq;
  logic [8:0] roundUp;
  logic [5:0] nBursts;
  logic rowHit;
  logic issueAct;
  logic issuePre;
  logic issueCol;
  logic lastBurst;
  logic apNow;
  dcs_cmd_t next_cmd;

  //////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Byte address to bank, row and column
  function automatic dcs_loc_t mapAddr(input logic [31:0] a, input logic mode);
    dcs_loc_t l;
    l.col = a[`DCS_COL_LSB +: 10];
    if (mode == `DCS_MAP_INTERLEAVE) begin
      l.bank = a[`DCS_ILV_BANK_LSB +: 3];
      l.row = a[`DCS_ILV_ROW_LSB +: 13];
    end else begin
      l.row = a[`DCS_LIN_ROW_LSB +: 13];
      l.bank = a[`DCS_LIN_BANK_LSB +: 3];
    end
    return l;
  endfunction : mapAddr

  // Master ID compare on the masked bits
  function automatic logic idMatch(input dcs_req_t r);
    return r.valid && (((r.masterId ^ priorityMasterId) & priorityIdMask) == 16'h0000);
  endfunction : idMatch

  //////////////////////////////////////////////////////////////////////////////
  // Arbitration

  // Priority match first, then alternate between ports
  always_comb begin
    anyReq = req0.valid || req1.valid;
    if (req0.valid && req1.valid) begin
      if (idMatch(req1) && !idMatch(req0)) begin
        pickOne = 1'b1;
      end else if (idMatch(req0) && !idMatch(req1)) begin
        pickOne = 1'b0;
      end else begin
        pickOne = !rrLast;
      end
    end else begin
      pickOne = req1.valid;
    end
    pickReq = pickOne ? req1 : req0;
    roundUp = {1'b0, pickReq.size} + 9'(`DCS_BURST_BYTES - 1);
    nBursts = roundUp[8:`DCS_BURST_SHIFT];
    if (nBursts == 6'h00) begin
      nBursts = 6'h01;
    end
  end

  // Request capture and burst walk
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      state <= DCS_ST_IDLE;
      reqAccept <= 2'b00;
      curAddr <= 32'h0000_0000;
      curWrite <= 1'b0;
      burstsLeft <= 6'h00;
      rrLast <= 1'b0;
    end else begin
      reqAccept <= 2'b00;
      case (state)
        DCS_ST_IDLE: begin
          if (anyReq) begin
            reqAccept <= pickOne ? 2'b10 : 2'b01;
            rrLast <= pickOne;
            curAddr <= {pickReq.addr[31:`DCS_BURST_SHIFT], 3'h0};
            curWrite <= pickReq.write;
            burstsLeft <= nBursts;
            state <= DCS_ST_RUN;
          end
        end
        DCS_ST_RUN: begin
          if (issueCol) begin
            curAddr <= curAddr + 32'(`DCS_BURST_BYTES);
            burstsLeft <= burstsLeft - 6'h01;
            if (lastBurst) begin
              state <= DCS_ST_IDLE;
            end
          end
        end
        default: begin
          state <= DCS_ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Banks

  generate
    for (genvar b = 0; b < NBANK; b++) begin : g_bank
      dcs_bank u_bank (
        .mclk(mclk),
        .sysRst(sysRst),
        .doAct(doAct[b]),
        .doPre(doPre[b]),
        .doAutoPre(doAutoPre[b]),
        .actRow(loc.row),
        .actWait(actWait),
        .openFlag(bankOpen[b]),
        .openRow(openRowArr[b]),
        .ready(bankReady[b])
      );
      assign doAct[b] = issueAct && (loc.bank == 3'(b));
      assign doPre[b] = issuePre && (loc.bank == 3'(b));
      assign doAutoPre[b] = issueCol && apNow && (loc.bank == 3'(b));
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Command choice

  always_comb begin
    loc = mapAddr(curAddr, bankMappingMode);
    rowHit = bankOpen[loc.bank] && (openRowArr[loc.bank] == loc.row);
    lastBurst = (burstsLeft == 6'h01);
    issueAct = 1'b0;
    issuePre = 1'b0;
    issueCol = 1'b0;
    if (state == DCS_ST_RUN && bankReady[loc.bank]) begin
      if (rowHit) begin
        issueCol = 1'b1;
      end else if (bankOpen[loc.bank]) begin
        issuePre = 1'b1;
      end else begin
        issueAct = 1'b1;
      end
    end
    // Global bit wins over the per-bank enables; writes never auto precharge
    apNow = !curWrite && (globalReadAutoprecharge ||
            (perBankAutoprechargeEnables[loc.bank] && lastBurst));
    // Activate to column wait, shortened by additive latency
    if (4'(`DCS_TRCD_CYC - 1) > {1'b0, additiveLatency}) begin
      actWait = 4'(`DCS_TRCD_CYC - 1) - {1'b0, additiveLatency};
    end else begin
      actWait = 4'h0;
    end
    next_cmd.op = DCS_OP_NOP;
    if (issueAct) begin
      next_cmd.op = DCS_OP_ACT;
    end else if (issuePre) begin
      next_cmd.op = DCS_OP_PRE;
    end else if (issueCol) begin
      next_cmd.op = curWrite ? DCS_OP_WR : DCS_OP_RD;
    end
    next_cmd.bank = loc.bank;
    next_cmd.row = loc.row;
    next_cmd.col = loc.col;
    next_cmd.autoPre = issueCol && apNow;
  end

  // Command register
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      cmdOut <= '0;
      issueLastQ <= 1'b0;
      prevOpen <= 8'h00;
    end else begin
      cmdOut <= next_cmd;
      issueLastQ <= issueCol && lastBurst;
      prevOpen <= bankOpen;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_global_ap;
    @(posedge mclk) disable iff (sysRst)
      (cmdOut.op == DCS_OP_RD) && $past(globalReadAutoprecharge) |-> cmdOut.autoPre;
  endproperty
  a_global_ap: assert property (p_global_ap) else $error("read without auto precharge");

  property p_bank_off;
    @(posedge mclk) disable iff (sysRst)
      (cmdOut.op == DCS_OP_RD) && !$past(globalReadAutoprecharge) &&
      ((($past(perBankAutoprechargeEnables) >> cmdOut.bank) & 8'h01) == 8'h00) |-> !cmdOut.autoPre;
  endproperty
  a_bank_off: assert property (p_bank_off) else $error("auto precharge on disabled bank");

  property p_mid_burst;
    @(posedge mclk) disable iff (sysRst)
      (cmdOut.op == DCS_OP_RD) && !$past(globalReadAutoprecharge) && !issueLastQ |-> !cmdOut.autoPre;
  endproperty
  a_mid_burst: assert property (p_mid_burst) else $error("per-bank precharge before last burst");

  property p_act_keeps;
    @(posedge mclk) disable iff (sysRst)
      (cmdOut.op == DCS_OP_ACT) |-> (bankOpen == (prevOpen | (8'h01 << cmdOut.bank)));
  endproperty
  a_act_keeps: assert property (p_act_keeps) else $error("activate disturbed another bank");

  property p_hit_col;
    @(posedge mclk) disable iff (sysRst)
      (cmdOut.op == DCS_OP_RD || cmdOut.op == DCS_OP_WR) |->
      prevOpen[cmdOut.bank] && (openRowArr[cmdOut.bank] == cmdOut.row);
  endproperty
  a_hit_col: assert property (p_hit_col) else $error("column command to a closed row");

  property p_pre_miss;
    @(posedge mclk) disable iff (sysRst)
      (cmdOut.op == DCS_OP_PRE) |-> prevOpen[cmdOut.bank] && (openRowArr[cmdOut.bank] != cmdOut.row);
  endproperty
  a_pre_miss: assert property (p_pre_miss) else $error("precharge on a row hit");

  property p_al_read;
    @(posedge mclk) disable iff (sysRst)
      (cmdOut.op == DCS_OP_ACT) && !curWrite && (actWait == 4'h0) |=> (cmdOut.op == DCS_OP_RD);
  endproperty
  a_al_read: assert property (p_al_read) else $error("read did not follow activate");

  property p_burst_step;
    @(posedge mclk) disable iff (sysRst)
      (cmdOut.op == DCS_OP_RD || cmdOut.op == DCS_OP_WR) |-> (cmdOut.col[1:0] == 2'b00);
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("burst not four-word aligned");

  property p_prio;
    @(posedge mclk) disable iff (sysRst)
      (state == DCS_ST_IDLE) && idMatch(req1) && req0.valid && !idMatch(req0) |=> (reqAccept == 2'b10);
  endproperty
  a_prio: assert property (p_prio) else $error("priority master lost arbitration");
endmodule : dcs_scheduler
`default_nettype wire

// ===== verif/dcs_dram_model.sv
// DRAM device model: tracks which banks are open and counts illegal commands.
// Assumes one command per mclk cycle from the scheduler.
`timescale 1ns/1ps
`default_nettype none
module dcs_dram_model
  import dcs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sysRst,
  // Command stream and latency setting
  input wire dcs_cmd_t cmdIn,
  input wire logic [2:0] alCyc,
  // Protocol errors seen
  output var int errCount
);
  logic [7:0] isOpen;
  int cyc;
  int actAt [8];
  int freeAt [8];
  dcs_bank_t b;
  assign b = cmdIn.bank;
  ////////////////////////////////////////////////////////////////
  // Bank state and timing checks per command
  always_ff @(posedge mclk) begin
    if (sysRst) begin
      isOpen <= '0;
      cyc <= 0;
      errCount <= 0;
    end else begin
      cyc <= cyc + 1;
      case (cmdIn.op)
        DCS_OP_ACT: begin
          if (isOpen[b] || cyc < freeAt[b]) errCount <= errCount + 1;
          isOpen[b] <= 1'b1;
          actAt[b] <= cyc;
        end
        DCS_OP_PRE: begin
          isOpen[b] <= 1'b0;
          freeAt[b] <= cyc + 2;
        end
        DCS_OP_RD, DCS_OP_WR: begin
          if (!isOpen[b] || cyc + alCyc < actAt[b] + 2 || cmdIn.col[1:0] != 2'b00) begin
            errCount <= errCount + 1;
          end
          if (cmdIn.autoPre) begin
            isOpen[b] <= 1'b0;
            freeAt[b] <= cyc + 2;
          end
        end
        default: ;
      endcase
    end
  end
endmodule : dcs_dram_model
`default_nettype wire

// ===== verif/ddr2_command_scheduler_test.sv
// Testbench of the DDR2 command scheduler: read transfers and arbitration.
// Assumes the scheduler, its package and the DRAM model in verif/.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module ddr2_command_scheduler_test;
  import dcs_pkg::*;
  logic mclk, sysRst, mode, glob, wrMode;
  logic [7:0] perBank, bankOpen;
  logic [15:0] prioId, prioMsk;
  logic [2:0] al;
  logic [1:0] acc;
  dcs_req_t req0, req1;
  dcs_cmd_t cmd;
  dcs_cmd_t got[$];
  int at[$];
  int cyc, failures, testsRun, errCnt;
  ////////////////////////////////////////////////////////////////
  // Design and DRAM model
  dcs_scheduler dut_u (.mclk(mclk), .sysRst(sysRst), .bankMappingMode(mode),
    .globalReadAutoprecharge(glob), .perBankAutoprechargeEnables(perBank),
    .priorityMasterId(prioId), .priorityIdMask(prioMsk), .additiveLatency(al),
    .req0(req0), .req1(req1), .reqAccept(acc), .cmdOut(cmd), .bankOpen(bankOpen));
  dcs_dram_model dramU (.mclk(mclk), .sysRst(sysRst), .cmdIn(cmd), .alCyc(al), .errCount(errCnt));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Command capture with cycle stamps
  always @(negedge mclk) begin
    cyc++;
    if (cmd.op !== DCS_OP_NOP) begin
      got.push_back(cmd);
      at.push_back(cyc);
    end
  end
  // Hang guard
  initial begin
    wait (cyc == 3000);
    failures++;
    stopTest();
  end
  ////////////////////////////////////////////////////////////////
  task waitAcc();
    int n;
    n = 0;
    while (acc === 2'b00 && n < 40) begin
      @(negedge mclk);
      n++;
    end
  endtask : waitAcc
  // One transfer on port 0, read or write per wrMode, then count the commands it caused
  task xfer(input string nm, input logic [31:0] a, input logic [7:0] sz, input int nCmd);
    int n;
    got.delete();
    at.delete();
    req0 = '{1'b1, 16'h0001, wrMode, a, sz};
    waitAcc();
    `CHK("accept", 2'b01, acc)
    req0.valid = 1'b0;
    n = 0;
    while (got.size() < nCmd && n < 40) begin
      @(negedge mclk);
      n++;
    end
    repeat (3) @(negedge mclk);
    `CHK("cmdCount", nCmd, got.size())
    $display("test %s done, failures %0d", nm, failures);
  endtask : xfer
  task expCmd(input int i, input dcs_op_t op, input dcs_bank_t bk, input logic [12:0] v, input logic ap);
    `CHK("op", op, got[i].op)
    `CHK("bank", bk, got[i].bank)
    if (op == DCS_OP_ACT) `CHK("row", v, got[i].row)
    else if (op != DCS_OP_PRE) `CHK("col", v[9:0], got[i].col)
    if (op == DCS_OP_RD) `CHK("autoPre", ap, got[i].autoPre)
  endtask : expCmd
  task stopTest();
    $display("checks %0d failures %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stopTest
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    sysRst = 1'b1;
    mode = 1'b0;
    wrMode = 1'b0;
    glob = 1'b0;
    perBank = 8'h00;
    prioId = 16'h0000;
    prioMsk = 16'hFFFF;
    al = 3'h0;
    req0 = '0;
    req1 = '0;
    repeat (5) @(negedge mclk);
    `CHK("rstCmd", 30'h0000_0000, cmd)
    `CHK("rstOpen", 8'h00, bankOpen)
    sysRst = 1'b0;
    xfer("closed", 32'h0001_4810, 8'h08, 2);
    expCmd(0, DCS_OP_ACT, 3'h1, 13'h0005, 1'b0);
    expCmd(1, DCS_OP_RD, 3'h1, 13'h0008, 1'b0);
    `CHK("actToRd", 2, at[1] - at[0])
    xfer("hit", 32'h0001_4820, 8'h08, 1);
    expCmd(0, DCS_OP_RD, 3'h1, 13'h0010, 1'b0);
    xfer("otherBank", 32'h0001_5000, 8'h08, 2);
    expCmd(0, DCS_OP_ACT, 3'h2, 13'h0005, 1'b0);
    `CHK("open2", 8'h06, bankOpen)
    xfer("miss", 32'h0001_8800, 8'h08, 3);
    expCmd(0, DCS_OP_PRE, 3'h1, 13'h0000, 1'b0);
    expCmd(1, DCS_OP_ACT, 3'h1, 13'h0006, 1'b0);
    expCmd(2, DCS_OP_RD, 3'h1, 13'h0000, 1'b0);
    perBank = 8'h02;
    xfer("perBank", 32'h0001_8800, 8'h20, 4);
    for (int i = 0; i < 4; i++) begin
      expCmd(i, DCS_OP_RD, 3'h1, 13'(4 * i), i == 3);
    end
    `CHK("closed1", 8'h04, bankOpen)
    glob = 1'b1;
    xfer("global", 32'h0001_8800, 8'h10, 4);
    expCmd(1, DCS_OP_RD, 3'h1, 13'h0000, 1'b1);
    expCmd(2, DCS_OP_ACT, 3'h1, 13'h0006, 1'b0);
    expCmd(3, DCS_OP_RD, 3'h1, 13'h0004, 1'b1);
    glob = 1'b0;
    perBank = 8'h00;
    al = 3'h1;
    xfer("addLat", 32'h0000_A000, 8'h08, 2);
    expCmd(0, DCS_OP_ACT, 3'h4, 13'h0002, 1'b0);
    `CHK("alGap", 1, at[1] - at[0])
    mode = 1'b1;
    xfer("linear", 32'h0500_1808, 8'h08, 2);
    expCmd(0, DCS_OP_ACT, 3'h5, 13'h0003, 1'b0);
    expCmd(1, DCS_OP_RD, 3'h5, 13'h0004, 1'b0);
    `CHK("open3", 8'h34, bankOpen)
    // Write hit with the global bit set: column only, never auto precharge
    wrMode = 1'b1;
    glob = 1'b1;
    xfer("write", 32'h0500_1810, 8'h08, 1);
    expCmd(0, DCS_OP_WR, 3'h5, 13'h0008, 1'b0);
    `CHK("wrNoAp", 1'b0, got[0].autoPre)
    `CHK("openWr", 8'h34, bankOpen)
    glob = 1'b0;
    wrMode = 1'b0;
    // Priority wins against the alternation order; middle pass is a plain tie
    for (int k = 0; k < 3; k++) begin
      prioId = (k == 0) ? 16'h000C : (k == 1) ? 16'h0000 : 16'h004C;
      req0 = '{1'b1, 16'h000C, 1'b0, 32'h0500_1808, 8'h08};
      req1 = '{1'b1, 16'h004C, 1'b0, 32'h0500_1810, 8'h08};
      waitAcc();
      `CHK("prioWin", (k == 0) ? 2'b01 : 2'b10, acc)
      req0.valid = 1'b0;
      req1.valid = 1'b0;
      repeat (10) @(negedge mclk);
    end
    $display("test priority done, failures %0d", failures);
    `CHK("dramErrors", 0, errCnt)
    stopTest();
  end
endmodule : ddr2_command_scheduler_test
`default_nettype wire
